// ===== pkg/trig_pkg.sv
// constants, offsets and types for the trigger port and reference select
package trig_pkg;
    localparam int CLK_MHZ = 125;
    localparam int ADDR_W = 5;
    // register byte addresses
    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_SWEEP_TIME = 5'h04;
    localparam logic [4:0] OFF_STEP_TIME = 5'h08;
    localparam logic [4:0] OFF_STATUS = 5'h0c;
    localparam logic [4:0] OFF_IRQ_STATUS = 5'h10;
    localparam logic [4:0] OFF_IRQ_MASK = 5'h14;
    // control field positions
    localparam int CTRL_SRC_EXT = 0;
    localparam int CTRL_POL_NEG = 1;
    localparam int CTRL_SLOPE_FALL = 2;
    localparam int CTRL_TOSEL_LSB = 3;
    localparam int CTRL_FUNC_LSB = 5;
    localparam int CTRL_REF_EXT = 7;
    localparam int CTRL_SYNC_LSB = 8;
    localparam int CTRL_W = 10;
    localparam logic [9:0] CTRL_RESET = 10'h000;
    localparam logic [31:0] TIME_RESET = 32'h0000_0000;
    // status field positions
    localparam int STAT_TRIG_LEVEL = 0;
    localparam int STAT_REF_EXT = 1;
    localparam int STAT_TRIG_OUT = 2;
    localparam int STAT_PULSE_BUSY = 3;
    // interrupt bits
    localparam int IRQ_TRIG = 0;
    localparam int IRQ_REF_ON = 1;
    localparam int IRQ_REF_OFF = 2;
    localparam int IRQ_W = 3;
    localparam logic [2:0] IRQ_RESET = 3'h0;
    // reference qualification timing
    localparam int WINDOW_NS = 10000;
    localparam int WINDOW_CYCLES = (WINDOW_NS * CLK_MHZ + 999) / 1000;
    localparam int LOSS_NS = 500;
    localparam int LOSS_CYCLES = LOSS_NS * CLK_MHZ / 1000;
    localparam int EDGES_NOMINAL = 100;
    localparam int EDGES_TOL = 2;
    localparam int QUAL_WINDOWS = 4;
    typedef enum logic [1:0] {
        TOSEL_CLOSED = 2'b00,
        TOSEL_RISING = 2'b01,
        TOSEL_FALLING = 2'b10,
        TOSEL_SPARE = 2'b11
    } tosel_type;
    typedef enum logic [1:0] {
        FUNC_CONT = 2'b00,
        FUNC_BURST = 2'b01,
        FUNC_SWEEP = 2'b10,
        FUNC_SEQ = 2'b11
    } func_type;
    typedef enum logic [1:0] {
        REF_IDLE = 2'b00,
        REF_QUALIFY = 2'b01,
        REF_LOCKED = 2'b10
    } ref_state_type;
endpackage

// ===== hdl/pin_sync.sv
// two-stage synchroniser for asynchronous pins
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // first stage feeds only the second stage
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

// ===== hdl/ref_clock_monitor.sv
// qualifies the external reference clock and detects its loss
`timescale 1ns/10ps
module ref_clock_monitor #(
    parameter int WINDOW_CYCLES = trig_pkg::WINDOW_CYCLES,
    parameter int LOSS_CYCLES = trig_pkg::LOSS_CYCLES
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic select_ext,
    input wire logic ref_level,
    output logic use_ext,
    output logic acquired,
    output logic removed
);
    trig_pkg::ref_state_type state_reg;
    logic last_reg;
    logic [15:0] win_reg;
    logic [15:0] edges_reg;
    logic [15:0] idle_reg;
    logic [3:0] good_reg;
    wire rise = ref_level & ~last_reg;
    wire win_end = (win_reg == 16'(WINDOW_CYCLES - 1));
    wire edges_ok = (edges_reg >= 16'(trig_pkg::EDGES_NOMINAL
                     - trig_pkg::EDGES_TOL)) &&
                    (edges_reg <= 16'(trig_pkg::EDGES_NOMINAL
                     + trig_pkg::EDGES_TOL));
    wire lost = (idle_reg >= 16'(LOSS_CYCLES));
    wire qual_done = win_end && edges_ok &&
                     (good_reg == 4'(trig_pkg::QUAL_WINDOWS - 1));

    assign use_ext = (state_reg == trig_pkg::REF_LOCKED);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            last_reg <= 1'b0;
            win_reg <= 16'h0000;
            edges_reg <= 16'h0000;
            idle_reg <= 16'h0000;
        end else begin
            last_reg <= ref_level;
            win_reg <= win_end ? 16'h0000 : win_reg + 16'h0001;
            edges_reg <= win_end ? 16'h0000 : edges_reg + 16'(rise);
            idle_reg <= rise ? 16'h0000 :
                        (lost ? idle_reg : idle_reg + 16'h0001);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_reg <= trig_pkg::REF_IDLE;
            good_reg <= 4'h0;
            acquired <= 1'b0;
            removed <= 1'b0;
        end else begin
            acquired <= 1'b0;
            removed <= 1'b0;
            unique case (state_reg)
                trig_pkg::REF_IDLE: begin
                    good_reg <= 4'h0;
                    if (select_ext)
                        state_reg <= trig_pkg::REF_QUALIFY;
                end
                trig_pkg::REF_QUALIFY: begin
                    if (!select_ext) begin
                        state_reg <= trig_pkg::REF_IDLE;
                    end else if (qual_done) begin
                        state_reg <= trig_pkg::REF_LOCKED;
                        acquired <= 1'b1;
                    end else if (win_end) begin
                        good_reg <= edges_ok ? good_reg + 4'h1 : 4'h0;
                    end
                end
                trig_pkg::REF_LOCKED: begin
                    good_reg <= 4'h0;
                    if (!select_ext) begin
                        state_reg <= trig_pkg::REF_IDLE;
                    end else if (lost) begin
                        // falls back without software, then retries
                        state_reg <= trig_pkg::REF_QUALIFY;
                        removed <= 1'b1;
                    end
                end
                default: state_reg <= trig_pkg::REF_IDLE;
            endcase
        end
    end
endmodule

// ===== hdl/trigger_port_ctrl.sv
// trigger port, reference clock select and sync output control
`timescale 1ns/10ps
module trigger_port_ctrl #(
    parameter int WINDOW_CYCLES = trig_pkg::WINDOW_CYCLES,
    parameter int LOSS_CYCLES = trig_pkg::LOSS_CYCLES
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic trig_pin_in,
    output logic trig_pin_out,
    output logic trig_pin_oe_n,
    input wire logic reference_clock_port,
    output logic ref_use_ext,
    output logic int_osc_enable,
    input wire logic burst_active,
    input wire logic sweep_start,
    input wire logic sequence_start,
    output logic trig_event,
    output logic mod_level,
    input wire logic [1:0] sync_source,
    output logic channel_one_sync_output,
    output logic channel_two_sync_output,
    output logic irq
);
    ////////////////////////////////////////////////////////////////
    // register state
    logic [9:0] ctrl_reg;
    logic [31:0] sweep_time_reg;
    logic [31:0] step_time_reg;
    logic [2:0] irq_status_reg;
    logic [2:0] irq_mask_reg;
    logic served_reg;
    logic [31:0] pulse_cnt_reg;
    logic trig_last_reg;
    logic trig_out_val;

    ////////////////////////////////////////////////////////////////
    // control field decode
    wire src_ext = ctrl_reg[trig_pkg::CTRL_SRC_EXT];
    wire pol_neg = ctrl_reg[trig_pkg::CTRL_POL_NEG];
    wire slope_fall = ctrl_reg[trig_pkg::CTRL_SLOPE_FALL];
    wire ref_select_ext = ctrl_reg[trig_pkg::CTRL_REF_EXT];
    wire [1:0] sync_en =
        ctrl_reg[trig_pkg::CTRL_SYNC_LSB +: 2];
    trig_pkg::tosel_type trigger_output_select;
    trig_pkg::func_type func_sel;
    assign trigger_output_select = trig_pkg::tosel_type'(
        ctrl_reg[trig_pkg::CTRL_TOSEL_LSB +: 2]);
    assign func_sel = trig_pkg::func_type'(
        ctrl_reg[trig_pkg::CTRL_FUNC_LSB +: 2]);

    ////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [1:0] pins_sync;

    pin_sync #(
        .WIDTH(2)
    ) u_pin_sync (
        .ref_clk(ref_clk),
        .srst(srst),
        .async_in({reference_clock_port, trig_pin_in}),
        .sync_out(pins_sync)
    );

    wire trig_raw = pins_sync[0];
    wire ref_level = pins_sync[1];

    ////////////////////////////////////////////////////////////////
    // trigger input path
    // polarity applied before the edge test, so slope acts on logic value
    wire trig_logic = trig_raw ^ pol_neg;
    wire rise_seen = trig_logic & ~trig_last_reg;
    wire fall_seen = ~trig_logic & trig_last_reg;
    wire edge_hit = slope_fall ? fall_seen : rise_seen;

    always_ff @(posedge ref_clk) begin
        if (srst)
            trig_last_reg <= 1'b0;
        else
            trig_last_reg <= trig_logic;
    end

    // events only count while the pin is an input
    assign trig_event = src_ext & edge_hit;
    // modulation shares the pin, so it sees the raw level
    assign mod_level = trig_raw;

    ////////////////////////////////////////////////////////////////
    // internal trigger value
    wire sweep_go = (func_sel == trig_pkg::FUNC_SWEEP) & sweep_start;
    wire seq_go = (func_sel == trig_pkg::FUNC_SEQ) & sequence_start;
    wire [31:0] sweep_half = {1'b0, sweep_time_reg[31:1]};
    wire pulse_busy = (pulse_cnt_reg != 32'h0000_0000);

    always_ff @(posedge ref_clk) begin
        if (srst)
            pulse_cnt_reg <= 32'h0000_0000;
        else if (src_ext)
            pulse_cnt_reg <= 32'h0000_0000;
        else if (sweep_go)
            pulse_cnt_reg <= sweep_half;
        else if (seq_go)
            pulse_cnt_reg <= step_time_reg;
        else if (pulse_busy)
            pulse_cnt_reg <= pulse_cnt_reg - 32'h0000_0001;
    end

    always_comb begin
        unique case (func_sel)
            trig_pkg::FUNC_BURST: trig_out_val = burst_active;
            trig_pkg::FUNC_SWEEP: trig_out_val = pulse_busy;
            trig_pkg::FUNC_SEQ: trig_out_val = pulse_busy;
            trig_pkg::FUNC_CONT: trig_out_val = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // trigger pin drive
    wire drive_on = ~src_ext &
        ((trigger_output_select == trig_pkg::TOSEL_RISING) |
         (trigger_output_select == trig_pkg::TOSEL_FALLING));
    wire pin_level =
        (trigger_output_select == trig_pkg::TOSEL_FALLING) ?
        ~trig_out_val : trig_out_val;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            trig_pin_out <= 1'b0;
            trig_pin_oe_n <= 1'b1;
        end else begin
            trig_pin_out <= drive_on & pin_level;
            trig_pin_oe_n <= ~drive_on;
        end
    end

    ////////////////////////////////////////////////////////////////
    // reference clock selection
    logic ref_acquired;
    logic ref_removed;

    ref_clock_monitor #(
        .WINDOW_CYCLES(WINDOW_CYCLES),
        .LOSS_CYCLES(LOSS_CYCLES)
    ) u_ref_mon (
        .ref_clk(ref_clk),
        .srst(srst),
        .select_ext(ref_select_ext),
        .ref_level(ref_level),
        .use_ext(ref_use_ext),
        .acquired(ref_acquired),
        .removed(ref_removed)
    );

    // internal oscillator runs whenever the external one is not in use
    assign int_osc_enable = ~ref_use_ext;

    ////////////////////////////////////////////////////////////////
    // sync outputs
    logic [1:0] sync_gated;

    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_sync
            always_ff @(posedge ref_clk) begin
                if (srst)
                    sync_gated[ch] <= 1'b0;
                else
                    sync_gated[ch] <= sync_en[ch] & sync_source[ch];
            end
        end
    endgenerate

    assign channel_one_sync_output = sync_gated[0];
    assign channel_two_sync_output = sync_gated[1];

    ////////////////////////////////////////////////////////////////
    // bus slave: one wait cycle, then the answer
    wire bus_req = avs_read | avs_write;
    wire bus_done = bus_req & served_reg;
    wire wr_go = avs_write & bus_done;
    wire rd_take = bus_req & ~served_reg;
    wire sel_ctrl = (avs_address == trig_pkg::OFF_CTRL);
    wire sel_sweep = (avs_address == trig_pkg::OFF_SWEEP_TIME);
    wire sel_step = (avs_address == trig_pkg::OFF_STEP_TIME);
    wire sel_stat = (avs_address == trig_pkg::OFF_STATUS);
    wire sel_isr = (avs_address == trig_pkg::OFF_IRQ_STATUS);
    wire sel_imr = (avs_address == trig_pkg::OFF_IRQ_MASK);

    assign avs_waitrequest = bus_req & ~served_reg;

    function automatic logic [31:0] merge(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] be
    );
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++)
            if (be[b])
                res[b*8 +: 8] = new_val[b*8 +: 8];
        return res;
    endfunction

    wire [31:0] ctrl_wide = {22'h000000, ctrl_reg};
    wire [31:0] ctrl_merged = merge(ctrl_wide, avs_writedata,
                                    avs_byteenable);
    wire [31:0] sweep_merged = merge(sweep_time_reg, avs_writedata,
                                     avs_byteenable);
    wire [31:0] step_merged = merge(step_time_reg, avs_writedata,
                                    avs_byteenable);
    wire [2:0] w1c = (wr_go & sel_isr & avs_byteenable[0]) ?
                     avs_writedata[2:0] : 3'h0;
    wire [2:0] irq_events = {ref_removed, ref_acquired, trig_event};

    wire [31:0] status_word = {28'h0000000, pulse_busy, trig_out_val,
                               ref_use_ext, trig_logic};

    wire [31:0] rd_mux =
        sel_ctrl ? ctrl_wide :
        sel_sweep ? sweep_time_reg :
        sel_step ? step_time_reg :
        sel_stat ? status_word :
        sel_isr ? {29'h00000000, irq_status_reg} :
        sel_imr ? {29'h00000000, irq_mask_reg} :
        32'h0000_0000;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            served_reg <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            served_reg <= rd_take;
            if (rd_take && avs_read)
                avs_readdata <= rd_mux;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ctrl_reg <= trig_pkg::CTRL_RESET;
            sweep_time_reg <= trig_pkg::TIME_RESET;
            step_time_reg <= trig_pkg::TIME_RESET;
            irq_mask_reg <= trig_pkg::IRQ_RESET;
        end else if (wr_go) begin
            if (sel_ctrl)
                ctrl_reg <= ctrl_merged[9:0];
            if (sel_sweep)
                sweep_time_reg <= sweep_merged;
            if (sel_step)
                step_time_reg <= step_merged;
            if (sel_imr && avs_byteenable[0])
                irq_mask_reg <= avs_writedata[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////
    // interrupts: a new event outweighs a clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (srst)
            irq_status_reg <= trig_pkg::IRQ_RESET;
        else
            irq_status_reg <= (irq_status_reg & ~w1c) | irq_events;
    end

    assign irq = |(irq_status_reg & irq_mask_reg);
endmodule

// ===== sim/trig_partner.sv
// far-side equipment: trigger line driver and external reference source
`timescale 1ns/10ps
module trig_partner (
    input wire logic drive_en,
    input wire logic drive_level,
    input wire logic ref_run,
    input wire logic dev_out,
    input wire logic dev_oe_n,
    output logic pin_level,
    output logic ref_out
);
    initial pin_level = 1'b0;
    // released line has no pull: flip it so a stale level never passes
    always @(dev_out or dev_oe_n or drive_en or drive_level) begin
        if (!dev_oe_n) begin
            pin_level = dev_out;
        end else if (drive_en) begin
            pin_level = drive_level;
        end else begin
            pin_level = !pin_level;
        end
    end
    // 10 mhz source, odd phase offset; stands still once removed
    initial begin
        ref_out = 1'b0;
        #37;
        forever begin
            #50;
            if (ref_run) begin
                ref_out = !ref_out;
            end
        end
    end
endmodule

// ===== sim/trigger_port_ctrl_assertions.sv
// concurrent checks on the trigger port controller ports
`timescale 1ns/10ps
module trigger_port_ctrl_assertions (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    input wire logic trig_pin_in,
    input wire logic trig_pin_out,
    input wire logic trig_pin_oe_n,
    input wire logic ref_use_ext,
    input wire logic burst_active,
    input wire logic trig_event,
    input wire logic mod_level,
    input wire logic [1:0] sync_source,
    input wire logic channel_one_sync_output
);
    logic [9:0] ctrl_reg, ctrl_next;
    logic [1:0] age_reg, live_reg;
    logic hit, drv, b_rise, b_fall;
    // shadow of control, aged so settled settings can be judged
    assign hit = avs_write && !avs_waitrequest && avs_address == 5'h00;
    assign ctrl_next[7:0] = avs_byteenable[0] ? avs_writedata[7:0]
        : ctrl_reg[7:0];
    assign ctrl_next[9:8] = avs_byteenable[1] ? avs_writedata[9:8]
        : ctrl_reg[9:8];
    assign drv = !ctrl_reg[0] && ^ctrl_reg[4:3];
    assign b_rise = !ctrl_reg[0] && ctrl_reg[6:3] == 4'h5;
    assign b_fall = !ctrl_reg[0] && ctrl_reg[6:3] == 4'h6;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ctrl_reg <= trig_pkg::CTRL_RESET;
            age_reg <= 2'h0;
            live_reg <= 2'h0;
        end else begin
            ctrl_reg <= hit ? ctrl_next : ctrl_reg;
            age_reg <= hit ? 2'h0 : age_reg + {1'b0, age_reg != 2'h3};
            live_reg <= live_reg + {1'b0, live_reg != 2'h3};
        end
    end
    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);
    port_release_a: assert property (
        age_reg == 2'h3 && !drv |-> trig_pin_oe_n)
        else $error("pin driven while released");
    port_drive_a: assert property (
        age_reg == 2'h3 && drv |-> !trig_pin_oe_n)
        else $error("pin not driven");
    burst_rise_a: assert property (
        age_reg == 2'h3 && b_rise |=> trig_pin_out == $past(burst_active))
        else $error("burst level wrong");
    burst_fall_a: assert property (
        age_reg == 2'h3 && b_fall |=> trig_pin_out != $past(burst_active))
        else $error("inverted burst level wrong");
    event_ext_a: assert property (
        age_reg == 2'h3 && !ctrl_reg[0] |-> !trig_event)
        else $error("event with internal source");
    sync_follow_a: assert property (
        age_reg == 2'h3 |=>
        channel_one_sync_output ==
        ($past(sync_source[0]) && $past(ctrl_reg[8])))
        else $error("sync output wrong");
    ref_internal_a: assert property (
        age_reg == 2'h3 && !ctrl_reg[7] |-> !ref_use_ext)
        else $error("external ref while deselected");
    ref_select_a: assert property (
        $rose(ref_use_ext) |-> ctrl_reg[7])
        else $error("switched without selection");
    mod_sync_a: assert property (
        live_reg == 2'h3 |-> mod_level == $past(trig_pin_in, 2))
        else $error("modulation level not synced");
    bus_wait_a: assert property (
        (avs_read || avs_write) && !$past(avs_read || avs_write)
        |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus wait not one cycle");
endmodule
bind trigger_port_ctrl trigger_port_ctrl_assertions chk (
    .ref_clk(ref_clk),
    .srst(srst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_waitrequest(avs_waitrequest),
    .trig_pin_in(trig_pin_in),
    .trig_pin_out(trig_pin_out),
    .trig_pin_oe_n(trig_pin_oe_n),
    .ref_use_ext(ref_use_ext),
    .burst_active(burst_active),
    .trig_event(trig_event),
    .mod_level(mod_level),
    .sync_source(sync_source),
    .channel_one_sync_output(channel_one_sync_output)
);

// ===== sim/trigger_port_ctrl_tb.sv
// self-checking bench for the trigger port controller
`timescale 1ns/10ps
module trigger_port_ctrl_tb;
    logic ref_clk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, rnd, tm;
    logic [31:0] seed = 32'h0000_0041;
    logic avs_waitrequest, trig_pin_out, trig_pin_oe_n, pin_level, ref_line;
    logic drive_en = 1'b1, drive_level = 1'b0, ref_run = 1'b0, lvl, pol;
    logic burst_active = 1'b0, sweep_start = 1'b0, sequence_start = 1'b0;
    logic ref_use_ext, int_osc_enable, trig_event, mod_level, irq, s1, s2;
    logic [1:0] sync_source = 2'h0;
    int error_cnt = 0, checks = 0, ev_cnt = 0, base, exp_ev, n, high;
    always #4 ref_clk = !ref_clk;
    always @(posedge ref_clk) if (trig_event === 1'b1) ev_cnt <= ev_cnt + 1;
    trigger_port_ctrl dut (.ref_clk(ref_clk), .srst(srst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .trig_pin_in(pin_level),
        .trig_pin_out(trig_pin_out), .trig_pin_oe_n(trig_pin_oe_n),
        .reference_clock_port(ref_line), .ref_use_ext(ref_use_ext),
        .int_osc_enable(int_osc_enable), .burst_active(burst_active),
        .sweep_start(sweep_start), .sequence_start(sequence_start),
        .trig_event(trig_event), .mod_level(mod_level),
        .sync_source(sync_source), .channel_one_sync_output(s1),
        .channel_two_sync_output(s2), .irq(irq));
    trig_partner far (.drive_en(drive_en), .drive_level(drive_level),
        .ref_run(ref_run), .dev_out(trig_pin_out),
        .dev_oe_n(trig_pin_oe_n), .pin_level(pin_level), .ref_out(ref_line));
    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // {oe_n, level}; spare select code stays closed
    function automatic logic [1:0] exp_drive(input int t, input logic v);
        if (t == 1) return {1'b0, v};
        if (t == 2) return {1'b0, !v};
        return 2'b10;
    endfunction
    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t bit %b expected %b", $time, got, exp);
        end
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
    endtask
    // holds the request until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [4:0] a,
        input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge ref_clk);
        // no limit here: only the watchdog ends a hung wait
        while (avs_waitrequest !== 1'b0) begin
            @(posedge ref_clk);
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #400000;
        error_cnt++;
        finish_test();
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        tick(5);
        srst <= 1'b0;
        tick(1);
        bus(1'b1, 5'h18, 32'hffff_ffff);
        for (int i = 0; i < 7; i++) begin
            bus(1'b0, 5'(i * 4), 32'h0);
            chk_word(rd, 32'h0);
        end
        chk_word({29'h0, trig_pin_oe_n, s1, s2}, 32'h4);
        $display("test reset done");
        for (int c = 0; c < 4; c++) begin
            pol = c[0];
            bus(1'b1, 5'h00, 32'(1 + c * 2));
            bus(1'b1, 5'h14, 32'(c % 2));
            bus(1'b1, 5'h10, 32'h7);
            base = ev_cnt;
            exp_ev = 0;
            for (int k = 0; k < 12; k++) begin
                rnd = xs();
                lvl = rnd[0];
                if ((drive_level ^ pol) != (lvl ^ pol) && (lvl ^ pol) != c[1])
                    exp_ev++;
                drive_level <= lvl;
                tick(4);
            end
            tick(2);
            chk_word(32'(ev_cnt - base), 32'(exp_ev));
            bus(1'b0, 5'h0c, 32'h0);
            chk_bit(rd[0], lvl ^ pol);
            chk_bit(mod_level, lvl);
            chk_bit(trig_pin_oe_n, 1'b1);
            chk_bit(irq, exp_ev > 0 && c[0]);
            bus(1'b1, 5'h10, 32'h1);
            tick(1);
            chk_bit(irq, 1'b0);
        end
        $display("test trigger input done");
        drive_en <= 1'b0;
        for (int t = 0; t < 4; t++) begin
            bus(1'b1, 5'h00, 32'(t * 8 + 32));
            tick(2);
            repeat (8) begin
                rnd = xs();
                burst_active <= rnd[0];
                tick(1);
                @(negedge ref_clk);
                chk_word({trig_pin_oe_n, trig_pin_out},
                    exp_drive(t, rnd[0]));
                @(posedge ref_clk);
            end
        end
        $display("test trigger output done");
        for (int f = 2; f < 4; f++) begin
            rnd = xs();
            tm = {26'h0, rnd[5:0]} + 32'h2;
            bus(1'b1, f == 2 ? 5'h04 : 5'h08, tm);
            bus(1'b1, 5'h00, 32'(f * 32 + 8));
            tick(2);
            sweep_start <= (f == 2);
            sequence_start <= (f == 3);
            tick(1);
            sweep_start <= 1'b0;
            sequence_start <= 1'b0;
            high = 0;
            repeat (80) begin
                @(negedge ref_clk);
                if (trig_pin_out === 1'b1) high++;
            end
            chk_word(32'(high), f == 2 ? tm >> 1 : tm);
            @(posedge ref_clk);
        end
        $display("test pulses done");
        for (int e = 0; e < 4; e++) begin
            // continuous function, falling select: port stands high
            bus(1'b1, 5'h00, 32'(e * 256 + 16));
            tick(2);
            repeat (4) begin
                rnd = xs();
                sync_source <= rnd[1:0];
                tick(1);
                @(negedge ref_clk);
                chk_word({s2, s1}, rnd[1:0] & 2'(e));
                chk_bit(trig_pin_out, 1'b1);
                @(posedge ref_clk);
            end
        end
        $display("test sync done");
        bus(1'b1, 5'h00, 32'h80);
        bus(1'b1, 5'h10, 32'h7);
        ref_run <= 1'b1;
        n = 0;
        while (ref_use_ext !== 1'b1 && n < 8000) begin
            tick(1);
            n++;
        end
        chk_bit(int_osc_enable, 1'b0);
        bus(1'b0, 5'h0c, 32'h0);
        chk_bit(rd[1], 1'b1);
        bus(1'b0, 5'h10, 32'h0);
        chk_word(rd, 32'h2);
        ref_run <= 1'b0;
        n = 0;
        while (ref_use_ext !== 1'b0 && n < 200) begin
            tick(1);
            n++;
        end
        chk_bit(n <= trig_pkg::LOSS_CYCLES + 8, 1'b1);
        chk_bit(int_osc_enable, 1'b1);
        bus(1'b0, 5'h10, 32'h0);
        chk_word(rd, 32'h6);
        $display("test reference done");
        finish_test();
    end
endmodule
